/* sim/sysctl_cpu_model.sv */
// processor-side model: issues moves, instruction checks, memory accesses
// assumes: block takes a request on the rising edge where valid is high
`timescale 1ns/1ps
module sysctl_cpu_model
  import sysctl_pkg::*;
(
  // clock
  input  wire logic        clock,
  // coprocessor move request
  output      logic        mv_valid,
  output      logic        mv_write,
  output      logic [1:0]  mv_el,
  output      logic [2:0]  mv_opc1,
  output      logic [2:0]  mv_opc2,
  output      logic [3:0]  mv_crn,
  output      logic [3:0]  mv_crm,
  output      logic [31:0] mv_wdata,
  // instruction check request
  output      logic        in_valid,
  output      logic [1:0]  in_el,
  output      logic        in_wait_for_irq_instr,
  output      logic        in_cond_pass,
  output      logic        in_would_sleep,
  output      logic        in_endian_switch,
  output      logic        in_barrier,
  output      logic [3:0]  in_coproc,
  output      logic        in_is_it,
  output      logic        in_after_it,
  output      logic [15:0] in_hw1,
  // memory access request
  output      logic        ma_valid,
  output      logic [1:0]  ma_el,
  output      logic        ma_fetch,
  output      logic        ma_normal,
  output      logic        ma_region_hit,
  output      logic        ma_misaligned,
  output      logic        ma_excl_acq_rel
);
  // ---------------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------------
  // encoding fields other than crn stay at the register's own code
  initial begin
    {mv_valid, mv_write, mv_el, mv_crn, mv_wdata} = '0;
    {mv_opc1, mv_opc2, mv_crm} = {ENC_OPC1, ENC_OPC2, ENC_CRM};
    {in_valid, in_el, in_wait_for_irq_instr, in_cond_pass} = '0;
    {in_would_sleep, in_endian_switch, in_barrier, in_coproc, in_is_it} = '0;
    {in_after_it, in_hw1} = '0;
    {ma_valid, ma_el, ma_fetch, ma_normal, ma_region_hit} = '0;
    {ma_misaligned, ma_excl_acq_rel} = '0;
  end

  // ---------------------------------------------------------------------
  // request tasks; each returns at the falling edge of the answer cycle
  // ---------------------------------------------------------------------
  // released data lines show the inverse so stale values never match
  task automatic mv(input logic wr, input logic [1:0] el,
                    input logic [3:0] crn, input logic [31:0] wd);
    @(negedge clock);
    {mv_valid, mv_write, mv_el, mv_crn, mv_wdata} = {1'h1, wr, el, crn, wd};
    @(negedge clock);
    {mv_valid, mv_wdata} = {1'h0, ~wd};
  endtask : mv

  // flags: wait, cond pass, would sleep, endian, barrier, is it, after it
  task automatic ins(input logic [1:0] el, input logic [6:0] f,
                     input logic [3:0] cp, input logic [15:0] hw);
    @(negedge clock);
    {in_valid, in_el, in_wait_for_irq_instr, in_cond_pass, in_would_sleep,
     in_endian_switch, in_barrier, in_is_it, in_after_it, in_coproc, in_hw1}
      = {1'h1, el, f, cp, hw};
    @(negedge clock);
    {in_valid, in_hw1} = {1'h0, ~hw};
  endtask : ins

  // flags: fetch, normal, region hit, misaligned, exclusive
  task automatic mem(input logic [1:0] el, input logic [4:0] f);
    @(negedge clock);
    {ma_valid, ma_el, ma_fetch, ma_normal, ma_region_hit, ma_misaligned,
     ma_excl_acq_rel} = {1'h1, el, f};
    @(negedge clock);
    ma_valid = 1'h0;
  endtask : mem
endmodule : sysctl_cpu_model

/* sim/sysctl_top_tb.sv */
// self-checking bench for the system control register block
// assumes: requests come from the cpu model, hyp controls from here
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module sysctl_top_tb
  import sysctl_pkg::*;
;
  // bit 6 reads back unknown, so it is never compared
  localparam logic [31:0] B6 = 32'hffff_ffbf;
  logic        clock, rstn, mv_valid, mv_write, mv_done_r, in_valid;
  logic        in_wait_for_irq_instr, in_cond_pass, in_would_sleep;
  logic        in_endian_switch, in_barrier, in_is_it, in_after_it;
  logic        in_done_r, in_undef_r;
  logic        ma_valid, ma_fetch, ma_normal, ma_region_hit, ma_misaligned;
  logic        ma_excl_acq_rel, ma_done_r, ma_region_fault_r;
  logic        ma_translation_fault_r, ma_align_fault_r, ma_cacheable_r;
  logic        ma_write_through_r, ma_background_r;
  logic [1:0]  mv_el, mv_result_r, in_el, ma_el;
  logic [2:0]  mv_opc1, mv_opc2;
  logic [3:0]  mv_crn, mv_crm, in_coproc;
  logic [4:0]  hyp;
  logic [15:0] in_hw1;
  logic [31:0] mv_wdata, mv_rdata_r, ctl_value_r;
  logic [15:0] pat [6] = '{16'hc000, 16'hb000, 16'ha000, 16'h4800,
                           16'h4478, 16'h4487};
  int          n_fail = 0;
  int          checks_done = 0;

  // ---------------------------------------------------------------------
  // clock and instances
  // ---------------------------------------------------------------------
  always #20 clock = ~clock;

  sysctl_top dut (.clock, .rstn, .hyp_default_cacheable(hyp[4]),
    .hyp_general_trap(hyp[3]), .hyp_vm_write_trap(hyp[2]),
    .hyp_vm_read_trap(hyp[1]), .hyp_sysreg_trap_one(hyp[0]),
    .mv_valid, .mv_write, .mv_el, .mv_opc1, .mv_opc2, .mv_crn, .mv_crm,
    .mv_wdata, .mv_done_r, .mv_result_r, .mv_rdata_r, .in_valid, .in_el,
    .in_wait_for_irq_instr, .in_cond_pass, .in_would_sleep,
    .in_endian_switch, .in_barrier,
    .in_coproc, .in_is_it, .in_after_it, .in_hw1, .in_done_r, .in_undef_r,
    .ma_valid, .ma_el, .ma_fetch, .ma_normal, .ma_region_hit, .ma_misaligned,
    .ma_excl_acq_rel, .ma_done_r, .ma_region_fault_r, .ma_translation_fault_r,
    .ma_align_fault_r, .ma_cacheable_r, .ma_write_through_r,
    .ma_background_r, .ctl_value_r);

  sysctl_cpu_model cpu (.clock, .mv_valid, .mv_write, .mv_el, .mv_opc1,
    .mv_opc2, .mv_crn, .mv_crm, .mv_wdata, .in_valid, .in_el,
    .in_wait_for_irq_instr,
    .in_cond_pass, .in_would_sleep, .in_endian_switch, .in_barrier,
    .in_coproc, .in_is_it, .in_after_it, .in_hw1, .ma_valid, .ma_el,
    .ma_fetch, .ma_normal, .ma_region_hit, .ma_misaligned, .ma_excl_acq_rel);

  // ---------------------------------------------------------------------
  // check helpers
  // ---------------------------------------------------------------------
  task automatic mvc(input logic wr, input logic [1:0] el,
    input logic [3:0] crn, input logic [31:0] wd, input logic [1:0] er,
    input logic [31:0] ed);
    cpu.mv(wr, el, crn, wd);
    `CHK({mv_done_r, mv_result_r}, {1'h1, er})
    `CHK(mv_rdata_r & B6, ed)
  endtask : mvc

  // write at EL2, read back, expect only documented bits to stick
  task automatic setr(input logic [31:0] v);
    logic [31:0] e;
    e = ((v & 32'h0003_11a7) | 32'h0000_0818) & B6;
    mvc(1'h1, SYSCTL_EL2, 4'h1, v, 2'h0, 32'h0);
    mvc(1'h0, SYSCTL_EL2, 4'h1, 32'h0, 2'h0, e);
    `CHK(ctl_value_r & B6, e)
  endtask : setr

  task automatic insc(input logic [1:0] el, input logic [6:0] f,
    input logic [3:0] cp, input logic [15:0] hw, input logic eu);
    cpu.ins(el, f, cp, hw);
    `CHK({in_done_r, in_undef_r}, {1'h1, eu})
  endtask : insc

  // expect: region, translation, align, cacheable, write-through, bkg
  task automatic memc(input logic [1:0] el, input logic [4:0] f,
    input logic [5:0] e);
    cpu.mem(el, f);
    `CHK({ma_done_r, ma_region_fault_r, ma_translation_fault_r,
          ma_align_fault_r, ma_cacheable_r, ma_write_through_r,
          ma_background_r}, {1'h1, e})
  endtask : memc

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------------
  // watchdog: the sequence needs well under 1000 cycles
  // ---------------------------------------------------------------------
  initial begin
    #(4000 * 40);
    n_fail++;
    end_sim();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    clock = 1'h0;
    rstn = 1'h0;
    hyp = 5'h00;
    repeat (8) @(negedge clock);
    rstn = 1'h1;
    `CHK(ctl_value_r & B6, 32'h0000_0818)
    setr(32'hffff_ffff);
    setr(32'h0000_0000);
    // refusals and traps; a refused write must leave the value alone
    mvc(1'h1, SYSCTL_EL0, 4'h1, 32'h1, 2'h1, 32'h0);
    mvc(1'h0, SYSCTL_EL0, 4'h1, 32'h0, 2'h1, 32'h0);
    mvc(1'h1, SYSCTL_EL1, 4'h9, 32'h1, 2'h1, 32'h0);
    mvc(1'h1, SYSCTL_EL1, 4'h1, 32'h1, 2'h0, 32'h0);
    hyp = 5'h01;
    mvc(1'h0, SYSCTL_EL1, 4'h1, 32'h0, 2'h2, 32'h0);
    hyp = 5'h04;
    mvc(1'h1, SYSCTL_EL1, 4'h1, 32'h0, 2'h2, 32'h0);
    mvc(1'h0, SYSCTL_EL1, 4'h1, 32'h0, 2'h0, 32'h819);
    hyp = 5'h02;
    mvc(1'h0, SYSCTL_EL1, 4'h1, 32'h0, 2'h2, 32'h0);
    mvc(1'h1, SYSCTL_EL1, 4'h1, 32'h1, 2'h0, 32'h0);
    hyp = 5'h08;
    mvc(1'h0, SYSCTL_EL1, 4'h1, 32'h0, 2'h1, 32'h0);
    hyp = 5'h09;
    mvc(1'h1, SYSCTL_EL1, 4'h1, 32'h0, 2'h1, 32'h0);
    hyp = 5'h0f;
    mvc(1'h0, SYSCTL_EL2, 4'h1, 32'h0, 2'h0, 32'h819);
    // memory checks with only the protection enable set, then with background, both caches and alignment check also set
    hyp = 5'h00;
    memc(SYSCTL_EL1, 5'h08, 6'h20);
    memc(SYSCTL_EL0, 5'h08, 6'h10);
    memc(SYSCTL_EL1, 5'h1c, 6'h00);
    memc(SYSCTL_EL1, 5'h0e, 6'h00);
    memc(SYSCTL_EL1, 5'h0f, 6'h08);
    hyp = 5'h10;
    memc(SYSCTL_EL1, 5'h0c, 6'h04);
    memc(SYSCTL_EL0, 5'h1c, 6'h04);
    memc(SYSCTL_EL2, 5'h0c, 6'h00);
    hyp = 5'h08;
    memc(SYSCTL_EL1, 5'h08, 6'h00);
    memc(SYSCTL_EL1, 5'h18, 6'h00);
    hyp = 5'h00;
    setr(32'h0002_1007);
    memc(SYSCTL_EL1, 5'h08, 6'h05);
    memc(SYSCTL_EL0, 5'h08, 6'h14);
    memc(SYSCTL_EL1, 5'h1c, 6'h04);
    memc(SYSCTL_EL1, 5'h0e, 6'h0c);
    memc(SYSCTL_EL1, 5'h04, 6'h00);
    hyp = 5'h08;
    memc(SYSCTL_EL1, 5'h1c, 6'h06);
    hyp = 5'h00;
    // instruction checks with trap-disable, endian, it and barrier clear, then with all four set
    insc(SYSCTL_EL0, 7'h70, 4'h0, 16'h0, 1'h1);
    insc(SYSCTL_EL0, 7'h50, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL0, 7'h60, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h70, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h04, 4'hf, 16'h0, 1'h1);
    insc(SYSCTL_EL1, 7'h04, 4'he, 16'h0, 1'h0);
    insc(SYSCTL_EL2, 7'h04, 4'hf, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h08, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h02, 4'h0, 16'hbf14, 1'h0);
    setr(32'h0001_01a0);
    insc(SYSCTL_EL0, 7'h70, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h08, 4'h0, 16'h0, 1'h1);
    insc(SYSCTL_EL2, 7'h08, 4'h0, 16'h0, 1'h0);
    insc(SYSCTL_EL0, 7'h04, 4'hf, 16'h0, 1'h0);
    insc(SYSCTL_EL1, 7'h02, 4'h0, 16'hbf14, 1'h1);
    insc(SYSCTL_EL1, 7'h02, 4'h0, 16'hbf18, 1'h0);
    // restricted followers, condition failing and passing
    for (int i = 0; i < 6; i++) begin
      insc(SYSCTL_EL0, 7'h01, 4'h0, pat[i], 1'h1);
      insc(SYSCTL_EL1, 7'h21, 4'h0, pat[i], 1'h1);
    end
    insc(SYSCTL_EL1, 7'h01, 4'h0, 16'h2000, 1'h0);
    insc(SYSCTL_EL1, 7'h01, 4'h0, 16'ha800, 1'h0);
    insc(SYSCTL_EL2, 7'h01, 4'h0, 16'hc000, 1'h0);
    end_sim();
  end
endmodule : sysctl_top_tb

/* src/sysctl_ctl_if.sv */
// control-bit bundle passed from the register to the checkers
// assumes: driven by one register module, read by the checker module
`timescale 1ns/1ps
interface sysctl_ctl_if;
  logic bkg_region;
  logic wait_for_irq_trap_disable;
  logic icache;
  logic endian_disable;
  logic it_restrict;
  logic barrier_enable;
  logic dcache;
  logic align_check;
  logic pu_enable_eff;

  modport src (output bkg_region, wait_for_irq_trap_disable, icache,
               endian_disable, it_restrict, barrier_enable, dcache,
               align_check, pu_enable_eff);
  modport dst (input  bkg_region, wait_for_irq_trap_disable, icache,
               endian_disable, it_restrict, barrier_enable, dcache,
               align_check, pu_enable_eff);
endinterface : sysctl_ctl_if

/* src/sysctl_ifthen_chk.sv */
// decode of if-then restricted halfwords
// assumes: halfword inputs come from same-clock decoder logic
`timescale 1ns/1ps
module sysctl_ifthen_chk
  import sysctl_pkg::*;
(
  // instruction halfwords
  input  wire logic [15:0] it_hw1,
  input  wire logic [15:0] next_hw1,
  // results
  output      logic        it_bad,
  output      logic        next_bad
);

  // ---------------------------------------------------------------------
  // restricted pattern match of the instruction after if-then
  // ---------------------------------------------------------------------
  function automatic logic sysctl_restricted(input logic [15:0] h);
    sysctl_restricted = (h[15:14] == 2'h3)                     // 32-bit
                     || (h[15:12] == 4'hb)                     // misc 16
                     || (h[15:11] == 5'h14)                    // add pc
                     || (h[15:11] == 5'h09)                    // ldr pc
                     || ({h[15:12], h[10]} == 5'h09 && h[6:3] == 4'hf)
                     || (h[15:10] == 6'h11 && h[7] && h[2:0] == 3'h7);
  endfunction : sysctl_restricted

  // if-then itself only allowed with low nibble 1000
  assign it_bad   = (it_hw1[3:0] != IT_PLAIN);
  // condition pass does not matter here
  assign next_bad = sysctl_restricted(next_hw1);

endmodule : sysctl_ifthen_chk

/* src/sysctl_pkg.sv */
// system control bits: constants, field positions and enumerations
// assumes: single 25 MHz processor clock domain
package sysctl_pkg;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int unsigned BIT_BKG_REGION   = 17;
  localparam int unsigned BIT_WAIT_NOTRAP  = 16;
  localparam int unsigned BIT_ICACHE       = 12;
  localparam int unsigned BIT_ENDIAN_DIS   = 8;
  localparam int unsigned BIT_IT_RESTRICT  = 7;
  localparam int unsigned BIT_UNKNOWN      = 6;
  localparam int unsigned BIT_BARRIER_EN   = 5;
  localparam int unsigned BIT_DCACHE       = 2;
  localparam int unsigned BIT_ALIGN_CHK    = 1;
  localparam int unsigned BIT_PU_ENABLE    = 0;

  // ---------------------------------------------------------------------
  // coprocessor move encoding of the register
  // ---------------------------------------------------------------------
  localparam logic [2:0] ENC_OPC1 = 3'h0;
  localparam logic [2:0] ENC_OPC2 = 3'h0;
  localparam logic [3:0] ENC_CRN  = 4'h1;
  localparam logic [3:0] ENC_CRM  = 4'h0;

  // ---------------------------------------------------------------------
  // values and reset
  // ---------------------------------------------------------------------
  // writable lower-half bits (bit 6 ignores writes)
  localparam logic [31:0] WR_MASK     = 32'h0003_11a7;
  // fixed ones in the lower half (bits 11, 4, 3)
  localparam logic [31:0] FIXED_ONES  = 32'h0000_0818;
  // bits are unknown at reset; a defined zero is kept for the flops
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [3:0]  IT_PLAIN    = 4'h8;
  localparam logic [3:0]  BARRIER_CP  = 4'hf;

  // exception levels of the requester
  typedef enum logic [1:0] {
    SYSCTL_EL0 = 2'h0,
    SYSCTL_EL1 = 2'h1,
    SYSCTL_EL2 = 2'h2
  } sysctl_el_t;

  // outcome of a coprocessor move
  typedef enum logic [1:0] {
    SYSCTL_ACC_OK,
    SYSCTL_ACC_UNDEF,
    SYSCTL_ACC_HYP_TRAP
  } sysctl_acc_t;

endpackage : sysctl_pkg

/* src/sysctl_top.sv */
// system control register, lower half, with access traps and checks
// assumes: one 25 MHz clock; decoder and protection unit share it;
// requests are one-cycle pulses from same-clock logic
`timescale 1ns/1ps
// Behaviour
// - no-region EL1 access faults, background off
// - background on: no-region EL1 access permitted
// - no-region EL0 access always translation faults
// - EL0 wait-for-irq traps when disable clear
// - conditional wait traps only when passing
// - icache bit clear: fetches non-cacheable
// - icache bit set: fetches cacheable
// - hyp default cacheable forces fetch cacheable
// - endian disable makes switch undefined
// - if-then nibble not 1000 undefined
// - restricted follower halfwords undefined
// - undefined regardless of condition pass
// - bit 6 ignores writes, reads unknown
// - barrier disable makes barriers undefined
// - dcache bit steers data cacheability
// - hyp default cacheable forces data cacheable
// - alignment bit clear: no ordinary check
// - alignment bit set: misaligned faults
// - exclusive and acquire always checked
// - general trap hides enable, reads stored
// - vm write and read traps
// - reachable EL1/EL2 only, sysreg trap
module sysctl_top
  import sysctl_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // hypervisor controls
  input  wire logic        hyp_default_cacheable,
  input  wire logic        hyp_general_trap,
  input  wire logic        hyp_vm_write_trap,
  input  wire logic        hyp_vm_read_trap,
  input  wire logic        hyp_sysreg_trap_one,
  // coprocessor move request
  input  wire logic        mv_valid,
  input  wire logic        mv_write,
  input  wire logic [1:0]  mv_el,
  input  wire logic [2:0]  mv_opc1,
  input  wire logic [2:0]  mv_opc2,
  input  wire logic [3:0]  mv_crn,
  input  wire logic [3:0]  mv_crm,
  input  wire logic [31:0] mv_wdata,
  // coprocessor move answer
  output      logic        mv_done_r,
  output      logic [1:0]  mv_result_r,
  output      logic [31:0] mv_rdata_r,
  // instruction check request
  input  wire logic        in_valid,
  input  wire logic [1:0]  in_el,
  input  wire logic        in_wait_for_irq_instr,
  input  wire logic        in_cond_pass,
  input  wire logic        in_would_sleep,
  input  wire logic        in_endian_switch,
  input  wire logic        in_barrier,
  input  wire logic [3:0]  in_coproc,
  input  wire logic        in_is_it,
  input  wire logic        in_after_it,
  input  wire logic [15:0] in_hw1,
  // instruction check answer
  output      logic        in_done_r,
  output      logic        in_undef_r,
  // memory access request
  input  wire logic        ma_valid,
  input  wire logic [1:0]  ma_el,
  input  wire logic        ma_fetch,
  input  wire logic        ma_normal,
  input  wire logic        ma_region_hit,
  input  wire logic        ma_misaligned,
  input  wire logic        ma_excl_acq_rel,
  // memory access answer
  output      logic        ma_done_r,
  output      logic        ma_region_fault_r,
  output      logic        ma_translation_fault_r,
  output      logic        ma_align_fault_r,
  output      logic        ma_cacheable_r,
  output      logic        ma_write_through_r,
  output      logic        ma_background_r,
  // live control levels
  output      logic [31:0] ctl_value_r
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  logic        unknown_bit_r;
  logic        mv_hit;
  logic        mv_trap;
  logic        mv_undef;
  logic        it_bad;
  logic        next_bad;
  logic        in_lowel;
  logic        ma_lowel;

  sysctl_ctl_if ctl ();

  // encoding match of this register
  assign mv_hit = (mv_opc1 == ENC_OPC1) && (mv_opc2 == ENC_OPC2)
               && (mv_crn == ENC_CRN) && (mv_crm == ENC_CRM);

  // EL0 and EL1 under general trap cannot reach it
  assign mv_undef = !mv_hit || (mv_el == SYSCTL_EL0)
                 || (mv_el == SYSCTL_EL1 && hyp_general_trap);
  // EL1 traps: sysreg trap on any, vm traps by direction
  assign mv_trap = (mv_el == SYSCTL_EL1) && (hyp_sysreg_trap_one
                 || (mv_write && hyp_vm_write_trap)
                 || (!mv_write && hyp_vm_read_trap));

  // masked write; bit 6 is not in the mask, fixed bits forced
  assign ctl_nxt = (mv_wdata & WR_MASK) | FIXED_ONES;

  // ---------------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctl_r <= RESET_VALUE | FIXED_ONES;
    end else if (mv_valid && mv_write && !mv_undef && !mv_trap) begin
      ctl_r <= ctl_nxt;
    end
  end

  // free-running bit gives the unknown value of bit 6
  always_ff @(posedge clock) begin
    if (!rstn) begin
      unknown_bit_r <= 1'b0;
    end else begin
      unknown_bit_r <= ~unknown_bit_r;
    end
  end

  // move answer; reads show stored enable even under general trap
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mv_done_r   <= 1'b0;
      mv_result_r <= SYSCTL_ACC_OK;
      mv_rdata_r  <= 32'h0000_0000;
    end else begin
      mv_done_r <= mv_valid;
      if (mv_valid) begin
        if (mv_undef) begin
          mv_result_r <= SYSCTL_ACC_UNDEF;
          mv_rdata_r  <= 32'h0000_0000;
        end else if (mv_trap) begin
          mv_result_r <= SYSCTL_ACC_HYP_TRAP;
          mv_rdata_r  <= 32'h0000_0000;
        end else begin
          mv_result_r <= SYSCTL_ACC_OK;
          mv_rdata_r  <= mv_write ? 32'h0000_0000
                       : {ctl_r[31:7], unknown_bit_r, ctl_r[5:0]};
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // control levels to the checkers
  // ---------------------------------------------------------------------
  assign ctl.bkg_region       = ctl_r[BIT_BKG_REGION];
  assign ctl.wait_for_irq_trap_disable = ctl_r[BIT_WAIT_NOTRAP];
  assign ctl.icache           = ctl_r[BIT_ICACHE];
  assign ctl.endian_disable   = ctl_r[BIT_ENDIAN_DIS];
  assign ctl.it_restrict      = ctl_r[BIT_IT_RESTRICT];
  assign ctl.barrier_enable   = ctl_r[BIT_BARRIER_EN];
  assign ctl.dcache           = ctl_r[BIT_DCACHE];
  assign ctl.align_check      = ctl_r[BIT_ALIGN_CHK];
  // general trap makes the unit look disabled
  assign ctl.pu_enable_eff    = ctl_r[BIT_PU_ENABLE]
                             && !hyp_general_trap;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctl_value_r <= RESET_VALUE | FIXED_ONES;
    end else begin
      ctl_value_r <= ctl_r;
    end
  end

  sysctl_ifthen_chk u_it (
    .it_hw1   (in_hw1),
    .next_hw1 (in_hw1),
    .it_bad   (it_bad),
    .next_bad (next_bad)
  );

  // ---------------------------------------------------------------------
  // instruction checks
  // ---------------------------------------------------------------------
  assign in_lowel = (in_el == SYSCTL_EL0) || (in_el == SYSCTL_EL1);

  // any one cause makes the instruction undefined
  always_ff @(posedge clock) begin
    if (!rstn) begin
      in_done_r  <= 1'b0;
      in_undef_r <= 1'b0;
    end else begin
      in_done_r  <= in_valid;
      in_undef_r <= in_valid && (
          (in_wait_for_irq_instr && in_el == SYSCTL_EL0
             && in_cond_pass && in_would_sleep
             && !ctl.wait_for_irq_trap_disable)
       || (in_lowel && in_endian_switch && ctl.endian_disable)
       || (in_lowel && in_barrier && in_coproc == BARRIER_CP
             && !ctl.barrier_enable)
       || (in_lowel && ctl.it_restrict && in_is_it && it_bad)
       || (in_lowel && ctl.it_restrict && in_after_it
             && next_bad));
    end
  end

  // ---------------------------------------------------------------------
  // memory access attributes and faults
  // ---------------------------------------------------------------------
  assign ma_lowel = (ma_el == SYSCTL_EL0) || (ma_el == SYSCTL_EL1);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ma_done_r              <= 1'b0;
      ma_region_fault_r      <= 1'b0;
      ma_translation_fault_r <= 1'b0;
      ma_background_r        <= 1'b0;
    end else begin
      ma_done_r <= ma_valid;
      ma_region_fault_r <= ma_valid && ctl.pu_enable_eff && !ma_region_hit
                         && ma_el == SYSCTL_EL1 && !ctl.bkg_region;
      ma_background_r   <= ma_valid && ctl.pu_enable_eff && !ma_region_hit
                         && ma_el == SYSCTL_EL1 && ctl.bkg_region;
      ma_translation_fault_r <= ma_valid && ctl.pu_enable_eff
                         && !ma_region_hit && ma_el == SYSCTL_EL0;
    end
  end

  // alignment: ordinary accesses only when enabled, special always
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ma_align_fault_r <= 1'b0;
    end else begin
      ma_align_fault_r <= ma_valid && ma_lowel && !ma_fetch
        && ma_misaligned && (ma_excl_acq_rel
        || ctl.align_check);
    end
  end

  // cacheability; default-cacheable overrides both bits
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ma_cacheable_r     <= 1'b0;
      ma_write_through_r <= 1'b0;
    end else begin
      ma_cacheable_r <= ma_valid && ma_lowel && ma_normal
        && (hyp_default_cacheable
        || (ma_fetch ? ctl.icache : ctl.dcache));
      // unit off: fetches write-through when icache bit set
      ma_write_through_r <= ma_valid && ma_lowel && ma_fetch
        && !ctl.pu_enable_eff && ctl.icache;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_bkg_fault: assert property (@(posedge clock) disable iff (!rstn)
    ma_valid && ma_el == SYSCTL_EL1 && !ma_region_hit
    && ctl_r[BIT_PU_ENABLE] && !hyp_general_trap && !ctl_r[BIT_BKG_REGION]
    |=> ma_region_fault_r && !ma_background_r)
    else $error("missing background fault");
  a_el0_xlate: assert property (@(posedge clock) disable iff (!rstn)
    ma_valid && ma_el == SYSCTL_EL0 && !ma_region_hit && ctl.pu_enable_eff
    |=> ma_translation_fault_r && !ma_region_fault_r)
    else $error("el0 miss without translation fault");
  a_wait_trap: assert property (@(posedge clock) disable iff (!rstn)
    in_valid && in_wait_for_irq_instr && in_el == SYSCTL_EL0 && in_cond_pass
    && in_would_sleep && !ctl_r[BIT_WAIT_NOTRAP] |=> in_undef_r)
    else $error("wait for irq not trapped");
  a_align_excl: assert property (@(posedge clock) disable iff (!rstn)
    ma_valid && ma_lowel && !ma_fetch && ma_misaligned && ma_excl_acq_rel
    |=> ma_align_fault_r)
    else $error("exclusive misalign not faulted");
  a_dc_force: assert property (@(posedge clock) disable iff (!rstn)
    ma_valid && ma_lowel && ma_normal && hyp_default_cacheable
    |=> ma_cacheable_r)
    else $error("default cacheable ignored");
  a_vm_wtrap: assert property (@(posedge clock) disable iff (!rstn)
    mv_valid && mv_hit && mv_write && mv_el == SYSCTL_EL1
    && !hyp_general_trap && hyp_vm_write_trap
    |=> mv_result_r == SYSCTL_ACC_HYP_TRAP && $stable(ctl_r))
    else $error("vm write trap missed");
  a_el0_undef: assert property (@(posedge clock) disable iff (!rstn)
    mv_valid && mv_el == SYSCTL_EL0
    |=> mv_result_r == SYSCTL_ACC_UNDEF)
    else $error("el0 reached the register");
  a_bit6_wi: assert property (@(posedge clock) disable iff (!rstn)
    ##1 ctl_r[BIT_UNKNOWN] == 1'b0)
    else $error("bit 6 stored a write");
  a_endian_undef: assert property (@(posedge clock) disable iff (!rstn)
    in_valid && in_lowel && in_endian_switch && ctl_r[BIT_ENDIAN_DIS]
    |=> in_undef_r)
    else $error("endian switch not undefined");

endmodule : sysctl_top
